// ---- core/axis_cmd_regs.vh ----
/*
 * Register map, field positions and reset values of the axis command front end.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned byte addresses.
 */
`ifndef AXIS_CMD_REGS_VH
`define AXIS_CMD_REGS_VH

// Byte offsets
`define OFS_INSTR       8'h00
`define OFS_TARGET      8'h04
`define OFS_DISTANCE    8'h08
`define OFS_FLOOR       8'h0C
`define OFS_CEILING     8'h10
`define OFS_AXIS_STATE  8'h14
`define OFS_SYNC_CMD    8'h18
`define OFS_PROP_TWO    8'h1C
`define OFS_CUR_SPEED   8'h20
`define OFS_CMD_STATUS  8'h24

// Mirrored status word fields
`define F_MOTION_HI     23
`define F_MOTION_LO     21
`define F_CMD_HI        20
`define F_CMD_LO        16
`define F_SYNC_CMD_HI   19
`define F_HALT          15
`define F_SYNC_ARMED    14
`define F_SENSOR_ANY    13
`define F_PATTERN_HI    12
`define F_PATTERN_LO    8
`define F_OUT_HI        7
`define F_OUT_LO        4
`define F_IN_HI         3
`define F_IN_LO         0

// Property group two bits
`define P_AUTO_START    0
`define P_AUTOFIX       1
`define P_REDUCTION     2
`define P_DIST_MODE     3
`define P_STOP_TYPE     4

// Command status bits
`define S_ERROR         0
`define S_BUSY          1

// Reset values
`define RST_SPEED       14'h0000
`define RST_COORD       24'h000000
`define RST_PROP        5'h00

// Speed limits in pulses per second
`define SPEED_MAX_PPS   14'h30D4
`define SPEED_MIN_PPS   14'h0001

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ---- core/byte_lane_merge.v ----
/*
 * Merges AXI4-Lite write data into a stored register by byte strobe.
 * Assumes the register is at most 32 bits and sits in the low lanes.
 */
`default_nettype none

module byte_lane_merge #(
	parameter W = 24
) (
	input  wire [W-1:0] old_value,
	input  wire [31:0]  wdata,
	input  wire [3:0]   wstrb,
	output wire [W-1:0] merged
);

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1)
		begin : g_bit
			assign merged[i] = wstrb[i / 8] ? wdata[i] : old_value[i];
		end
	endgenerate

endmodule // byte_lane_merge

`default_nettype wire

// ---- core/speed_guard.v ----
/*
 * Range check and correction of the speed floor and ceiling pair.
 * Purely combinational; the caller samples it when a command is issued.
 */
`default_nettype none

module speed_guard #(
	parameter [13:0] SPEED_MIN = 14'h0001,
	parameter [13:0] SPEED_MAX = 14'h30D4,
	parameter [13:0] MIN_SPAN  = 14'h0000
) (
	input  wire [13:0] floor_in,
	input  wire [13:0] ceiling_in,
	output wire        in_range,
	output wire [13:0] floor_fix,
	output wire [13:0] ceiling_fix
);

	wire [13:0] f_clamp;
	wire [13:0] c_clamp;
	wire [14:0] span_top;

	assign f_clamp  = (floor_in < SPEED_MIN) ? SPEED_MIN :
	                  (floor_in > SPEED_MAX) ? SPEED_MAX : floor_in;
	assign c_clamp  = (ceiling_in < SPEED_MIN) ? SPEED_MIN :
	                  (ceiling_in > SPEED_MAX) ? SPEED_MAX : ceiling_in;
	assign span_top = {1'b0, f_clamp} + {1'b0, MIN_SPAN};

	// Transition width: ceiling must stand at least MIN_SPAN above floor
	assign in_range = (floor_in == f_clamp) && (ceiling_in == c_clamp) &&
	                  ({1'b0, ceiling_in} >= span_top);

	// Raising the ceiling is preferred to lowering the floor
	assign ceiling_fix = ({1'b0, c_clamp} >= span_top) ? c_clamp :
	                     (span_top > {1'b0, SPEED_MAX}) ? SPEED_MAX : span_top[13:0];
	assign floor_fix   = ({1'b0, ceiling_fix} >= span_top) ? f_clamp :
	                     ceiling_fix - MIN_SPAN;

endmodule // speed_guard

`default_nettype wire

// ---- core/axis_command_front.v ----
/*
 * Register front end of one pulse motion axis: instruction, target,
 * distance and speed registers, plus mirrored status, over AXI4-Lite.
 * Assumes the pulse generator supplies motion state and current speed,
 * and acts on cmd_valid; all pins are synchronous to aclk.
 */
// Overview of operation
// - Bits 23:21 report direction and motion phase.
// - Command field bits 20:16 issue axis instructions.
// - Bit 15 shows active all-stop pin.
// - Bit 14 shows sync prepared, awaiting trigger.
// - Bit 13 ORs all limit and origin sensors.
// - Bits 12:8 hold writable pattern number.
// - Bits 7:4 drive general-purpose output pins.
// - Bits 3:0 monitor general-purpose input pins.
// - Other instruction bits are read-only status.
// - Status fields identical across three mirrored registers.
// - Target coordinate is 24-bit two's complement.
// - Target write auto-starts stopped axis if enabled.
// - Distance signed or unsigned by mode bit.
// - Distance write auto-starts stopped axis if enabled.
// - Speed registers 14 bits, upper bits zero.
// - Floor write ignored while moving with stop-type.
// - Autofix corrects bad speeds and continues.
// - Without autofix bad speeds abort with error.
// - Current speed reads zero while stopped.
`default_nettype none
`include "axis_cmd_regs.vh"

module axis_command_front #(
	parameter [4:0]  MOVE_TO_TARGET_CMD   = 5'h01,
	parameter [4:0]  MOVE_BY_DISTANCE_CMD = 5'h02,
	parameter [13:0] MIN_SPAN             = 14'h0000
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        ce,
	// AXI4-Lite slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Axis state from the pulse generator and pins
	input  wire [2:0]  motion_state_field,
	input  wire        all_stop_n,
	input  wire        sync_armed_flag,
	input  wire [4:0]  limit_sensor_bits,
	input  wire [3:0]  input_port_bits,
	input  wire [13:0] current_speed,
	// Command to the pulse generator
	output reg         cmd_valid,
	output reg  [4:0]  cmd_code,
	output reg  [4:0]  cmd_pattern,
	output reg  [23:0] cmd_target,
	output reg  [24:0] cmd_distance,
	output reg  [13:0] cmd_speed_floor,
	output reg  [13:0] cmd_speed_ceiling,
	output reg         cmd_short_reduction,
	output reg         cmd_stop_type,
	output reg         cmd_refused,
	output reg  [3:0]  output_port_bits,
	output reg  [3:0]  sync_cmd_code
);

	reg  [7:0]  aw_addr_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	reg  [4:0]  command_q;
	reg  [4:0]  pattern_index_q;
	reg  [23:0] target_coordinate_q;
	reg  [23:0] travel_distance_q;
	reg  [13:0] speed_floor_q;
	reg  [13:0] speed_ceiling_q;
	reg  [4:0]  property_group_two_q;
	reg         pend_q;
	reg  [4:0]  pend_code_q;
	reg         error_q;
	reg  [31:0] rd_d;
	reg         rd_ok;

	wire        wr_go;
	wire        axis_stopped;
	wire        sensor_any_flag;
	wire [31:0] status_word;
	wire        floor_locked;
	wire        instr_cmd_wr;
	wire        auto_start_hit;
	wire        guard_ok;
	wire [13:0] floor_fix;
	wire [13:0] ceiling_fix;
	wire [23:0] target_m;
	wire [23:0] distance_m;
	wire [13:0] floor_m;
	wire [13:0] ceiling_m;
	wire [23:0] instr_m;
	wire [4:0]  prop_m;
	wire [19:16] sync_m;
	wire        autofix;
	wire        auto_start_on_write;
	wire        distance_mode_select;
	wire        stop_type_select;

	assign autofix              = property_group_two_q[`P_AUTOFIX];
	assign auto_start_on_write  = property_group_two_q[`P_AUTO_START];
	assign distance_mode_select = property_group_two_q[`P_DIST_MODE];
	assign stop_type_select     = property_group_two_q[`P_STOP_TYPE];

	assign wr_go        = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign axis_stopped = (motion_state_field[1:0] == 2'h0);

	assign sensor_any_flag = |limit_sensor_bits;

	// Common status word; every mirror reads from this one source
	assign status_word = {8'h00,
		motion_state_field,
		5'h00,
		~all_stop_n,
		sync_armed_flag,
		sensor_any_flag,
		5'h00,
		output_port_bits,
		input_port_bits};

	byte_lane_merge #(.W(24)) u_merge_target (
		.old_value (target_coordinate_q),
		.wdata     (w_data_q),
		.wstrb     (w_strb_q),
		.merged    (target_m)
	);

	byte_lane_merge #(.W(24)) u_merge_distance (
		.old_value (travel_distance_q),
		.wdata     (w_data_q),
		.wstrb     (w_strb_q),
		.merged    (distance_m)
	);

	byte_lane_merge #(.W(14)) u_merge_floor (
		.old_value (speed_floor_q),
		.wdata     (w_data_q),
		.wstrb     (w_strb_q),
		.merged    (floor_m)
	);

	byte_lane_merge #(.W(14)) u_merge_ceiling (
		.old_value (speed_ceiling_q),
		.wdata     (w_data_q),
		.wstrb     (w_strb_q),
		.merged    (ceiling_m)
	);

	byte_lane_merge #(.W(24)) u_merge_instr (
		.old_value ({3'h0, command_q, 3'h0, pattern_index_q, output_port_bits, 4'h0}),
		.wdata     (w_data_q),
		.wstrb     (w_strb_q),
		.merged    (instr_m)
	);

	byte_lane_merge #(.W(5)) u_merge_prop (
		.old_value (property_group_two_q),
		.wdata     (w_data_q),
		.wstrb     (w_strb_q),
		.merged    (prop_m)
	);

	speed_guard #(
		.SPEED_MIN   (`SPEED_MIN_PPS),
		.SPEED_MAX   (`SPEED_MAX_PPS),
		.MIN_SPAN    (MIN_SPAN)
	) u_guard (
		.floor_in    (speed_floor_q),
		.ceiling_in  (speed_ceiling_q),
		.in_range    (guard_ok),
		.floor_fix   (floor_fix),
		.ceiling_fix (ceiling_fix)
	);

	assign sync_m = w_strb_q[2] ? w_data_q[19:16] : sync_cmd_code;

	// Protects the deceleration floor against a sudden limit stop
	assign floor_locked = stop_type_select && !axis_stopped;

	// An instruction command is issued only when the lane holding its field is written
	assign instr_cmd_wr   = wr_go && (aw_addr_q == `OFS_INSTR) && w_strb_q[2];
	assign auto_start_hit = wr_go && auto_start_on_write && axis_stopped &&
	                        ((aw_addr_q == `OFS_TARGET) || (aw_addr_q == `OFS_DISTANCE));

	// Write channel handshakes and register stores
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready        <= 1'b1;
			s_axi_wready         <= 1'b1;
			s_axi_bvalid         <= 1'b0;
			s_axi_bresp          <= `RESP_OKAY;
			aw_addr_q            <= 8'h00;
			w_data_q             <= 32'h00000000;
			w_strb_q             <= 4'h0;
			command_q            <= 5'h00;
			pattern_index_q      <= 5'h00;
			output_port_bits     <= 4'h0;
			target_coordinate_q  <= `RST_COORD;
			travel_distance_q    <= `RST_COORD;
			speed_floor_q        <= `RST_SPEED;
			speed_ceiling_q      <= `RST_SPEED;
			property_group_two_q <= `RST_PROP;
			sync_cmd_code        <= 4'h0;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_addr_q     <= {s_axi_awaddr[7:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RESP_OKAY;
				case (aw_addr_q)
					`OFS_INSTR:
					begin
						// Status bits are not stored; only writable fields
						command_q        <= instr_m[20:16];
						pattern_index_q  <= instr_m[12:8];
						output_port_bits <= instr_m[7:4];
					end
					`OFS_TARGET:     target_coordinate_q <= target_m;
					`OFS_DISTANCE:   travel_distance_q   <= distance_m;
					`OFS_FLOOR:
					begin
						if (!floor_locked)
							speed_floor_q <= floor_m;
					end
					`OFS_CEILING:    speed_ceiling_q     <= ceiling_m;
					`OFS_PROP_TWO:   property_group_two_q <= prop_m;
					`OFS_SYNC_CMD:   sync_cmd_code       <= sync_m;
					`OFS_AXIS_STATE,
					`OFS_CUR_SPEED,
					`OFS_CMD_STATUS: s_axi_bresp <= `RESP_OKAY;
					default:         s_axi_bresp <= `RESP_SLVERR;
				endcase
			end
			// Correction rewrites the stored pair so software sees what ran
			if (pend_q && !guard_ok && autofix)
			begin
				speed_floor_q   <= floor_fix;
				speed_ceiling_q <= ceiling_fix;
			end
		end
	end

	// Issue pipeline: capture, check one cycle later, then start or refuse
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pend_q              <= 1'b0;
			pend_code_q         <= 5'h00;
			cmd_valid           <= 1'b0;
			cmd_refused         <= 1'b0;
			cmd_code            <= 5'h00;
			cmd_pattern         <= 5'h00;
			cmd_target          <= `RST_COORD;
			cmd_distance        <= 25'h0000000;
			cmd_speed_floor     <= `RST_SPEED;
			cmd_speed_ceiling   <= `RST_SPEED;
			cmd_short_reduction <= 1'b0;
			cmd_stop_type       <= 1'b0;
			error_q             <= 1'b0;
		end
		else if (ce)
		begin
			cmd_valid   <= 1'b0;
			cmd_refused <= 1'b0;
			pend_q      <= instr_cmd_wr || auto_start_hit;
			if (instr_cmd_wr)
				pend_code_q <= instr_m[20:16];
			else if (aw_addr_q == `OFS_TARGET)
				pend_code_q <= MOVE_TO_TARGET_CMD;
			else
				pend_code_q <= MOVE_BY_DISTANCE_CMD;

			// Clear by writing one; a new error in the same cycle wins
			if (wr_go && (aw_addr_q == `OFS_CMD_STATUS) && w_strb_q[0] && w_data_q[`S_ERROR])
				error_q <= 1'b0;

			if (pend_q)
			begin
				if (guard_ok || autofix)
				begin
					cmd_valid           <= 1'b1;
					cmd_code            <= pend_code_q;
					cmd_pattern         <= pattern_index_q;
					cmd_target          <= target_coordinate_q;
					// Relative distance sign-extends, absolute zero-extends
					cmd_distance        <= distance_mode_select ?
						{1'b0, travel_distance_q} :
						{travel_distance_q[23], travel_distance_q};
					cmd_speed_floor     <= guard_ok ? speed_floor_q : floor_fix;
					cmd_speed_ceiling   <= guard_ok ? speed_ceiling_q : ceiling_fix;
					cmd_short_reduction <= property_group_two_q[`P_REDUCTION];
					cmd_stop_type       <= stop_type_select;
				end
				else
				begin
					cmd_refused <= 1'b1;
					error_q     <= 1'b1;
				end
			end
		end
	end

	// Read data selection; mirrors share status_word
	always @*
	begin
		rd_d  = 32'h00000000;
		rd_ok = 1'b1;
		case ({s_axi_araddr[7:2], 2'b00})
			`OFS_INSTR:
				rd_d = {status_word[31:21], command_q,
				        status_word[15:13], pattern_index_q, status_word[7:0]};
			`OFS_AXIS_STATE:
				rd_d = {status_word[31:13], limit_sensor_bits, status_word[7:0]};
			`OFS_SYNC_CMD:
				rd_d = {status_word[31:20], sync_cmd_code,
				        status_word[15:13], pattern_index_q, status_word[7:0]};
			`OFS_TARGET:     rd_d = {8'h00, target_coordinate_q};
			`OFS_DISTANCE:   rd_d = {8'h00, travel_distance_q};
			`OFS_FLOOR:      rd_d = {18'h00000, speed_floor_q};
			`OFS_CEILING:    rd_d = {18'h00000, speed_ceiling_q};
			`OFS_PROP_TWO:   rd_d = {27'h0000000, property_group_two_q};
			`OFS_CUR_SPEED:  rd_d = axis_stopped ? 32'h00000000 : {18'h00000, current_speed};
			`OFS_CMD_STATUS: rd_d = {30'h00000000, pend_q, error_q};
			default:         rd_ok = 1'b0;
		endcase
	end

	// Read channel: one outstanding read, answered the cycle after address
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_d;
				s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // axis_command_front

`default_nettype wire

// ---- sim/axis_front_chk.sv ----
/*
 * Port checker for the axis command front end.
 * Assumes one clock and a synchronous active-low reset; bound to every instance.
 */
`default_nettype none
`include "axis_cmd_regs.vh"

module axis_front_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic [2:0]  motion_state_field,
	input wire logic        all_stop_n,
	input wire logic        sync_armed_flag,
	input wire logic [4:0]  limit_sensor_bits,
	input wire logic [3:0]  input_port_bits,
	input wire logic        cmd_valid,
	input wire logic        cmd_refused,
	input wire logic [13:0] cmd_speed_floor,
	input wire logic [13:0] cmd_speed_ceiling,
	input wire logic [3:0]  output_port_bits
);
	logic [7:0]  wa_q;
	logic [7:0]  ra_q;
	logic [31:0] wd_q;
	logic [3:0]  ws_q;
	logic [13:0] pin_q;
	logic [1:0]  still_q;
	wire  [13:0] pins = {motion_state_field, all_stop_n, sync_armed_flag, limit_sensor_bits, input_port_bits};
	wire         quiet = still_q == 2'h3;

	// Status compares only once pins have settled, so input sync delay is tolerated
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wa_q    <= 8'h00;
			ra_q    <= 8'h00;
			wd_q    <= 32'h00000000;
			ws_q    <= 4'h0;
			pin_q   <= 14'h0000;
			still_q <= 2'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
			if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
			if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
			if (s_axi_wvalid && s_axi_wready) ws_q <= s_axi_wstrb;
			pin_q   <= pins;
			still_q <= (pins != pin_q) ? 2'h0 : (quiet ? 2'h3 : still_q + 2'h1);
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_cmd_latency:
	assert property ($rose(s_axi_bvalid) && wa_q == `OFS_INSTR && ws_q[2]
		|-> !(cmd_valid || cmd_refused) ##1 (cmd_valid ^ cmd_refused))
		else $error("command answer not one edge after the store");
	a_pulse_single:
	assert property ((cmd_valid || cmd_refused) |=> !(cmd_valid || cmd_refused))
		else $error("command pulse longer than one cycle");
	a_speed_fixed:
	assert property (cmd_valid |-> cmd_speed_floor >= `SPEED_MIN_PPS && cmd_speed_ceiling <= `SPEED_MAX_PPS
		&& cmd_speed_ceiling >= cmd_speed_floor)
		else $error("command started with speeds out of range");
	a_out_pins:
	assert property ($rose(s_axi_bvalid) && wa_q == `OFS_INSTR && ws_q[0]
		|-> output_port_bits == wd_q[7:4])
		else $error("output pins differ from written data");
	a_status_mirror:
	assert property ($rose(s_axi_rvalid) && quiet && (ra_q == `OFS_INSTR || ra_q == `OFS_AXIS_STATE
		|| ra_q == `OFS_SYNC_CMD) |-> s_axi_rdata[23:21] == pin_q[13:11] && s_axi_rdata[15] == !pin_q[10]
		&& s_axi_rdata[14] == pin_q[9] && s_axi_rdata[13] == |pin_q[8:4]
		&& s_axi_rdata[3:0] == pin_q[3:0])
		else $error("mirrored status field wrong");
	a_speed_upper:
	assert property (s_axi_rvalid && (ra_q == `OFS_FLOOR || ra_q == `OFS_CEILING) |-> s_axi_rdata[31:14] == 18'h00000)
		else $error("speed register upper bits not zero");
	a_speed_idle:
	assert property ($rose(s_axi_rvalid) && quiet && ra_q == `OFS_CUR_SPEED && pin_q[12:11] == 2'h0
		|-> s_axi_rdata == 32'h00000000)
		else $error("current speed not zero while stopped");
	a_unmapped_err:
	assert property ($rose(s_axi_rvalid) && ra_q > `OFS_CMD_STATUS |-> s_axi_rresp == `RESP_SLVERR)
		else $error("unmapped read not answered with error");
endmodule // axis_front_chk

bind axis_command_front axis_front_chk chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .motion_state_field, .all_stop_n,
	.sync_armed_flag, .limit_sensor_bits, .input_port_bits, .cmd_valid, .cmd_refused, .cmd_speed_floor,
	.cmd_speed_ceiling, .output_port_bits);
`default_nettype wire

// ---- sim/far_axis_model.sv ----
/*
 * Behavioural pulse generator seen by the command front end.
 * Assumes cmd_valid is a one-cycle start pulse; runs a fixed ramp profile.
 */
`default_nettype none

module far_axis_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        cmd_valid,
	input  wire logic [13:0] cmd_speed_ceiling,
	input  wire logic        dir,
	output logic      [2:0]  motion_state_field,
	output logic      [13:0] current_speed
);
	logic [5:0] left_q;
	logic       dir_q;

	always @(posedge aclk)
	begin
		if (!aresetn)
			left_q <= 6'h00;
		else if (cmd_valid)
			left_q <= 6'h30;
		else if (left_q != 6'h00)
			left_q <= left_q - 6'h01;
		dir_q <= aresetn && (cmd_valid ? dir : dir_q);
	end

	// Ramp up, cruise, ramp down; long enough for several bus accesses mid-move
	assign motion_state_field = (left_q == 6'h00) ? 3'h0 : {dir_q, (left_q > 6'h20) ? 2'h1 : (left_q > 6'h10) ? 2'h2 : 2'h3};
	assign current_speed = (left_q == 6'h00) ? 14'h0000 : cmd_speed_ceiling;
endmodule // far_axis_model
`default_nettype wire

// ---- sim/tb_axis_command_and_motion_params.sv ----
/*
 * Register-level bench for the axis command front end over AXI4-Lite.
 * Assumes the far_axis_model partner and the bound port checker.
 */
`default_nettype none

module tb_axis_command_and_motion_params;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 0, aresetn = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0, rv;
	logic [1:0]  rs;
	logic        all_stop_n = 1, sync_armed_flag = 0;
	logic [4:0]  limit_sensor_bits = 0;
	logic [3:0]  input_port_bits = 0;
	wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmd_valid, cmd_refused;
	wire logic        cmd_short_reduction, cmd_stop_type;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [2:0]  motion_state_field;
	wire logic [4:0]  cmd_code, cmd_pattern;
	wire logic [23:0] cmd_target;
	wire logic [24:0] cmd_distance;
	wire logic [13:0] current_speed, cmd_speed_floor, cmd_speed_ceiling;
	wire logic [3:0]  output_port_bits, sync_cmd_code;
	int mismatches = 0, tests_run = 0, nv = 0, nr = 0, cyc = 0;

	axis_command_front #(.MOVE_TO_TARGET_CMD(5'h01), .MOVE_BY_DISTANCE_CMD(5'h02)) dut (.aclk, .aresetn, .ce(1'b1),
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .motion_state_field, .all_stop_n,
		.sync_armed_flag, .limit_sensor_bits, .input_port_bits, .current_speed, .cmd_valid, .cmd_code,
		.cmd_pattern, .cmd_target, .cmd_distance, .cmd_speed_floor, .cmd_speed_ceiling, .cmd_short_reduction,
		.cmd_stop_type, .cmd_refused, .output_port_bits, .sync_cmd_code);
	far_axis_model far (.aclk, .aresetn, .cmd_valid, .cmd_speed_ceiling, .dir(cmd_target[23]),
		.motion_state_field, .current_speed);

	always #5 aclk = ~aclk;
	always @(posedge aclk)
	begin
		cyc++;
		if (cmd_valid === 1'b1) nv++;
		if (cmd_refused === 1'b1) nr++;
		if (cyc == 20000)
		begin
			mismatches++;
			finish_test;
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end
		while (s_axi_bvalid !== 1'b1 && n < 50);
		rs = s_axi_bresp;
		s_axi_bready <= 0;
		if (n == 50) chk("bvalid", 1, s_axi_bvalid);
	endtask

	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 0;
		end
		while (s_axi_rvalid !== 1'b1 && n < 50);
		rv = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 0;
		chk(nm, e, rv & m);
	endtask

	// Command pulse lands one edge after the store edge
	task automatic settle;
		repeat (3) @(posedge aclk);
		#1;
	endtask

	task automatic wstop;
		int n;
		n = 0;
		while (motion_state_field[1:0] !== 2'h0 && n < 200)
		begin
			@(posedge aclk);
			n++;
		end
		repeat (4) @(posedge aclk);
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		wr(8'h0C, 32'hFFFFFFFF);
		rc("floor", 8'h0C, 32'hFFFFFFFF, 32'h3FFF);
		wr(8'h10, 32'h30D4);
		wr(8'h00, 32'h00030000);
		settle;
		chk("refused", 1, nr);
		chk("started", 0, nv);
		rc("error", 8'h24, 32'h1, 32'h1);
		wr(8'h24, 32'h1);
		rc("error", 8'h24, 32'h1, 32'h0);
		$display("test refusal done");
		wr(8'h1C, 32'h02);
		wr(8'h00, 32'h00030000);
		settle;
		chk("started", 1, nv);
		chk("code", 5'h03, cmd_code);
		chk("floor_used", 14'h30D4, cmd_speed_floor);
		rc("floor", 8'h0C, 32'hFFFFFFFF, 32'h30D4);
		$display("test autofix done");
		wstop;
		all_stop_n <= 0;
		sync_armed_flag <= 1;
		limit_sensor_bits <= 5'h04;
		input_port_bits <= 4'hA;
		wr(8'h00, 32'hFFFF155F);
		settle;
		chk("out_pins", 4'h5, output_port_bits);
		chk("code", 5'h1F, cmd_code);
		chk("pattern", 5'h15, cmd_pattern);
		wstop;
		rc("instr", 8'h00, 32'hFFFFFFFF, 32'h001FF55A);
		rc("axis", 8'h14, 32'hE0FFFF, 32'hE45A);
		wr(8'h18, 32'h000F0000);
		rc("sync", 8'h18, 32'hFFFFFFFF, 32'h000FF55A);
		chk("sync_code", 4'hF, sync_cmd_code);
		$display("test status done");
		wr(8'h1C, 32'h12);
		wr(8'h00, 32'h00030000);
		settle;
		chk("stop_type", 1, cmd_stop_type);
		wr(8'h0C, 32'h10);
		wr(8'h10, 32'h2000);
		rc("floor", 8'h0C, 32'hFFFFFFFF, 32'h30D4);
		rc("ceiling", 8'h10, 32'hFFFFFFFF, 32'h2000);
		rc("speed", 8'h20, 32'hFFFFFFFF, 32'h30D4);
		wstop;
		rc("speed", 8'h20, 32'hFFFFFFFF, 32'h0);
		wr(8'h0C, 32'h10);
		rc("floor", 8'h0C, 32'hFFFFFFFF, 32'h10);
		$display("test stop_type done");
		wr(8'h1C, 32'h07);
		wr(8'h04, 32'h00800000);
		settle;
		chk("started", 4, nv);
		chk("code", 5'h01, cmd_code);
		chk("target", 24'h800000, cmd_target);
		chk("reduction", 1, cmd_short_reduction);
		wr(8'h08, 32'h00800000);
		settle;
		chk("started", 4, nv);
		wstop;
		wr(8'h08, 32'h00800000);
		settle;
		chk("started", 5, nv);
		chk("code", 5'h02, cmd_code);
		chk("dist", 25'h1800000, cmd_distance);
		wstop;
		wr(8'h1C, 32'h0F);
		wr(8'h08, 32'h00800000);
		settle;
		chk("dist", 25'h0800000, cmd_distance);
		rc("target", 8'h04, 32'hFFFFFFFF, 32'h800000);
		$display("test auto_start done");
		rc("unmapped", 8'h40, 32'h0, 32'h0);
		chk("rresp", 2'h2, rs);
		wr(8'h40, 32'h0);
		chk("bresp", 2'h2, rs);
		$display("test unmapped done");
		finish_test;
	end
endmodule // tb_axis_command_and_motion_params
`default_nettype wire
